/* logic/dual_gpio_port.sv */
// Two 8-bit general-purpose ports with pin control and an AHB-Lite slave.
// Assumes pins, peripheral outputs and standby status are synchronous to
// clk; every output but the constant hresp is registered, so pads follow registers one cycle late.
`timescale 1ns/1ps

// Behaviour
// R1: direction 1 makes the pin an output
// R2: direction 0 makes the pin an input
// R3: output pins drive the data latch
// R4: output pin reads return the latch
// R5: input pin writes only update the latch
// R6: input reads give pin; RMW reads latch
// R7: peripheral drives pin; reads pin, RMW latch
// R8: software disables shared peripheral before port use
// R9: peripheral input needs direction 0, analog-disable 1
// R10: analog-disable 1 enables port 0 digital input
// R11: reset clears direction and analog-disable bits
// R12: isolated standby floats pins, inputs forced low
// R13: port 0 irq-enabled pins keep input path
// R14: standby without isolation keeps pins unchanged
// R15: analog use needs direction, disable, pull-up cleared
// R16: port 0 levels always reach the interrupt circuit; when isolated the code passes only ext_irq_enable pins
// R17: pull-up on when set, off driving low
// R18: comparator positive input on when enable-bar 0
// R19: comparator negative needs enable-bar and select 0
// R20: remap bit moves pulse outputs port 1/6
// R21: open-drain output writing 1 floats pin
// R22: port 1 bit 2 pull-up has no effect
// R23: bit n of each register controls pin n
module dual_gpio_port
  import gpio_pkg::*;
#(
  parameter logic [7:0] P1_OPEN_DRAIN = 8'h00
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        rmw_read,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // System status
  input  wire logic        stop_or_watch,
  input  wire logic [7:0]  ext_irq_enable,
  // Port 0 pads and sharing
  input  wire logic [7:0]  p0_pin_in,
  input  wire logic [7:0]  p0_periph_oe,
  input  wire logic [7:0]  p0_periph_out,
  output logic      [7:0]  p0_pin_out,
  output logic      [7:0]  p0_pin_oe_n,
  output logic      [7:0]  p0_pullup,
  output logic      [7:0]  p0_analog_en,
  output logic      [7:0]  p0_din,
  output logic      [7:0]  p0_irq_level,
  output logic      [1:0]  cmp_pos_en,
  output logic      [1:0]  cmp_neg_en,
  // Port 1 pads and pulse generator outputs
  input  wire logic [7:0]  p1_pin_in,
  input  wire logic [5:0]  pulse_oe,
  input  wire logic [5:0]  pulse_out,
  output logic      [7:0]  p1_pin_out,
  output logic      [7:0]  p1_pin_oe_n,
  output logic      [7:0]  p1_pullup,
  output logic      [7:0]  p1_din,
  // Pulse outputs remapped to port 6 bits 2..7
  output logic      [5:0]  p6_pulse_out,
  output logic      [5:0]  p6_pulse_en
);

  typedef struct packed {
    logic [7:0]  p0_lat;
    logic [7:0]  p0_dir;
    logic [7:0]  p0_pul;
    logic [7:0]  p0_adis;
    logic [7:0]  p1_lat;
    logic [7:0]  p1_dir;
    logic [7:0]  p1_pul;
    logic        standby_pin_state_bit;
    logic        remap;
    logic [1:0]  cmp_ien_n;
    logic [1:0]  cmp_neg;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [7:0]  p0_out;
    logic [7:0]  p0_oe_n;
    logic [7:0]  p0_pu;
    logic [7:0]  p0_aen;
    logic [7:0]  p0_din;
    logic [7:0]  p0_irq;
    logic [1:0]  cmp_pos;
    logic [1:0]  cmp_negen;
    logic [7:0]  p1_out;
    logic [7:0]  p1_oe_n;
    logic [7:0]  p1_pu;
    logic [7:0]  p1_din;
    logic [5:0]  p6_out;
    logic [5:0]  p6_en;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [7:0] p0_pad_out;
  logic [7:0] p0_pad_oe_n;
  logic [7:0] p0_pad_pu;
  logic [7:0] p0_rd;
  logic [7:0] p1_pad_out;
  logic [7:0] p1_pad_oe_n;
  logic [7:0] p1_pad_pu;
  logic [7:0] p1_rd;
  logic [7:0] p1_poe;
  logic [7:0] p1_pout;
  logic       isolate;

  // Data register read view: latch for port-driven outputs or RMW, pin otherwise
  function automatic logic [7:0] data_view(input logic [7:0] lat, input logic [7:0] dir,
                                           input logic [7:0] poe, input logic [7:0] pin,
                                           input logic rmw);
    logic [7:0] own;
    own = dir & ~poe;
    data_view = rmw ? lat : ((own & lat) | (~own & pin)); // R4 R6 R7
  endfunction

  function automatic logic [31:0] widen(input logic [7:0] v);
    widen = {24'h000000, v};
  endfunction

  assign isolate = stop_or_watch & s_q.standby_pin_state_bit; // R12 R14

  // Pulse generator routing onto port 1
  always_comb begin
    p1_poe  = 8'h00;
    p1_pout = 8'h00;
    for (int i = 0; i < 6; i++) begin
      p1_poe[PULSE_P1_PIN[i]]  = pulse_oe[i] & ~s_q.remap; // R20
      p1_pout[PULSE_P1_PIN[i]] = pulse_out[i];
    end
  end

  port_pad_ctrl #(.W(8)) u_port0 (
    .latch      (s_q.p0_lat),
    .dir        (s_q.p0_dir),
    .pull       (s_q.p0_pul),
    .no_pullup  (8'h00),
    .open_drain (8'h00),
    .in_enable  (s_q.p0_adis),
    .keep_in    (ext_irq_enable),
    .isolate    (isolate),
    .periph_oe  (p0_periph_oe),
    .periph_out (p0_periph_out),
    .pin_in     (p0_pin_in),
    .pad_out    (p0_pad_out),
    .pad_oe_n   (p0_pad_oe_n),
    .pad_pullup (p0_pad_pu),
    .pin_rd     (p0_rd)
  );

  port_pad_ctrl #(.W(8)) u_port1 (
    .latch      (s_q.p1_lat),
    .dir        (s_q.p1_dir),
    .pull       (s_q.p1_pul),
    .no_pullup  (P1_NO_PULLUP),
    .open_drain (P1_OPEN_DRAIN),
    .in_enable  (8'hff),
    .keep_in    (8'h00),
    .isolate    (isolate),
    .periph_oe  (p1_poe),
    .periph_out (p1_pout),
    .pin_in     (p1_pin_in),
    .pad_out    (p1_pad_out),
    .pad_oe_n   (p1_pad_oe_n),
    .pad_pullup (p1_pad_pu),
    .pin_rd     (p1_rd)
  );

  always_comb begin
    logic       addr_ok;
    logic [7:0] a;
    addr_ok = 1'b0;
    a       = 8'h00;
    s_d     = s_q;

    // Data phase of a write: any word-aligned write in the first 256 bytes lands here, whatever hsize
    if (s_q.wr_pend) begin
      case (s_q.wr_addr)
        OFF_P0_DATA: s_d.p0_lat  = hwdata[7:0]; // R3 R5 R23
        OFF_P0_DIR:  s_d.p0_dir  = hwdata[7:0]; // R1 R2
        OFF_P0_PUL:  s_d.p0_pul  = hwdata[7:0];
        OFF_P0_ADIS: s_d.p0_adis = hwdata[7:0]; // R10
        OFF_P1_DATA: s_d.p1_lat  = hwdata[7:0];
        OFF_P1_DIR:  s_d.p1_dir  = hwdata[7:0];
        OFF_P1_PUL:  s_d.p1_pul  = hwdata[7:0]; // R22
        OFF_CTRL: begin
          s_d.standby_pin_state_bit   = hwdata[CTRL_SPL_BIT];
          s_d.remap = hwdata[CTRL_REMAP_BIT];
        end
        OFF_CMP: begin
          for (int c = 0; c < 2; c++) begin
            s_d.cmp_ien_n[c] = hwdata[c*CMP_CH_STRIDE + CMP_IEN_N_BIT];
            s_d.cmp_neg[c]   = hwdata[c*CMP_CH_STRIDE + CMP_NEG_BIT];
          end
        end
        default: ;
      endcase
    end

    // Address phase; reads use values just written so back-to-back works
    s_d.wr_pend   = 1'b0;
    s_d.hreadyout = 1'b1;
    if (hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ)) begin
      a       = haddr[7:0];
      addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
      if (hwrite) begin
        s_d.wr_pend = addr_ok;
        s_d.wr_addr = a;
      end else begin
        case (a)
          OFF_P0_DATA: s_d.hrdata = widen(data_view(s_d.p0_lat, s_d.p0_dir,
                                          p0_periph_oe, p0_rd, rmw_read));
          OFF_P0_DIR:  s_d.hrdata = widen(s_d.p0_dir);
          OFF_P0_PUL:  s_d.hrdata = widen(s_d.p0_pul);
          OFF_P0_ADIS: s_d.hrdata = widen(s_d.p0_adis);
          OFF_P1_DATA: s_d.hrdata = widen(data_view(s_d.p1_lat, s_d.p1_dir,
                                          p1_poe, p1_rd, rmw_read));
          OFF_P1_DIR:  s_d.hrdata = widen(s_d.p1_dir);
          OFF_P1_PUL:  s_d.hrdata = widen(s_d.p1_pul);
          OFF_CTRL:    s_d.hrdata = widen({6'h00, s_d.remap, s_d.standby_pin_state_bit});
          OFF_CMP:     s_d.hrdata = widen({4'h0, s_d.cmp_neg[1], s_d.cmp_ien_n[1],
                                           s_d.cmp_neg[0], s_d.cmp_ien_n[0]});
          default:     s_d.hrdata = 32'h00000000;
        endcase
        if (!addr_ok) begin
          s_d.hrdata = 32'h00000000;
        end
      end
    end

    // Pad state; standby without isolation changes nothing
    s_d.p0_out  = p0_pad_out;
    s_d.p0_oe_n = p0_pad_oe_n;
    s_d.p0_pu   = p0_pad_pu;
    s_d.p0_aen  = ~s_q.p0_adis; // R10 R15
    s_d.p0_din  = p0_rd; // R9
    // Interrupt circuit sees the pin unless isolation blocks it
    s_d.p0_irq  = isolate ? (p0_pin_in & ext_irq_enable) : p0_pin_in; // R16 R13
    for (int c = 0; c < 2; c++) begin
      s_d.cmp_pos[c]   = ~s_q.cmp_ien_n[c] & ~s_q.p0_adis[CMP_POS_PIN[c]]; // R18
      s_d.cmp_negen[c] = ~s_q.cmp_ien_n[c] & ~s_q.cmp_neg[c]
                         & ~s_q.p0_adis[CMP_NEG_PIN[c]]; // R19
    end
    s_d.p1_out  = p1_pad_out;
    s_d.p1_oe_n = p1_pad_oe_n;
    s_d.p1_pu   = p1_pad_pu;
    s_d.p1_din  = p1_rd;
    // Port 6 pins take the pulse outputs when remapped
    s_d.p6_out  = pulse_out;
    s_d.p6_en   = pulse_oe & {6{s_q.remap}} & ~{6{isolate}}; // R20
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q           <= '0;
      s_q.p0_lat    <= RST_LATCH;
      s_q.p0_dir    <= RST_DIR; // R11
      s_q.p0_pul    <= RST_PUL;
      s_q.p0_adis   <= RST_ADIS; // R11
      s_q.p1_lat    <= RST_LATCH;
      s_q.p1_dir    <= RST_DIR; // R11
      s_q.p1_pul    <= RST_PUL;
      s_q.standby_pin_state_bit       <= RST_SPL;
      s_q.remap     <= RST_REMAP;
      s_q.cmp_ien_n <= RST_CMP_IEN;
      s_q.cmp_neg   <= RST_CMP_NEG;
      s_q.hreadyout <= 1'b1;
      s_q.p0_oe_n   <= 8'hff;
      s_q.p0_aen    <= 8'hff;
      s_q.p1_oe_n   <= 8'hff;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata       = s_q.hrdata;
  assign hreadyout    = s_q.hreadyout;
  assign hresp        = 1'b0;
  assign p0_pin_out   = s_q.p0_out;
  assign p0_pin_oe_n  = s_q.p0_oe_n;
  assign p0_pullup    = s_q.p0_pu;
  assign p0_analog_en = s_q.p0_aen;
  assign p0_din       = s_q.p0_din;
  assign p0_irq_level = s_q.p0_irq;
  assign cmp_pos_en   = s_q.cmp_pos;
  assign cmp_neg_en   = s_q.cmp_negen;
  assign p1_pin_out   = s_q.p1_out;
  assign p1_pin_oe_n  = s_q.p1_oe_n;
  assign p1_pullup    = s_q.p1_pu;
  assign p1_din       = s_q.p1_din;
  assign p6_pulse_out = s_q.p6_out;
  assign p6_pulse_en  = s_q.p6_en;

endmodule

/* logic/gpio_pkg.sv */
// Constants for the two-port pin control block: register map, field
// positions, reset values and bus encodings.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package gpio_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_P0_DATA = 8'h00;
  localparam logic [7:0] OFF_P0_DIR  = 8'h04;
  localparam logic [7:0] OFF_P0_PUL  = 8'h08;
  localparam logic [7:0] OFF_P0_ADIS = 8'h0c;
  localparam logic [7:0] OFF_P1_DATA = 8'h10;
  localparam logic [7:0] OFF_P1_DIR  = 8'h14;
  localparam logic [7:0] OFF_P1_PUL  = 8'h18;
  localparam logic [7:0] OFF_CTRL    = 8'h1c;
  localparam logic [7:0] OFF_CMP     = 8'h20;

  // Control register fields
  localparam int CTRL_SPL_BIT   = 0;
  localparam int CTRL_REMAP_BIT = 1;

  // Comparator register fields, two bits per channel
  localparam int CMP_IEN_N_BIT = 0;
  localparam int CMP_NEG_BIT   = 1;
  localparam int CMP_CH_STRIDE = 2;

  // Reset values
  localparam logic [7:0] RST_LATCH   = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'h00;
  localparam logic [7:0] RST_PUL     = 8'h00;
  localparam logic [7:0] RST_ADIS    = 8'h00;
  localparam logic       RST_SPL     = 1'b0;
  localparam logic       RST_REMAP   = 1'b0;
  localparam logic [1:0] RST_CMP_IEN = 2'h3;
  localparam logic [1:0] RST_CMP_NEG = 2'h0;

  // Pin positions
  localparam logic [7:0] P1_NO_PULLUP = 8'h04;
  localparam int CMP_POS_PIN [2] = '{0, 3};
  localparam int CMP_NEG_PIN [2] = '{1, 4};
  // Pulse outputs 00,01,10,11,20,21 on port 1 when not remapped
  localparam int PULSE_P1_PIN [6] = '{3, 4, 0, 1, 5, 6};
  localparam int PULSE_P6_BASE = 2;

  // AHB transfer types
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage

/* logic/port_pad_ctrl.sv */
// Combinational pad control for one 8-pin port: drive, enable, pull-up and
// gated digital input. Outputs are registered by the instantiating module.
`timescale 1ns/1ps
module port_pad_ctrl #(
  parameter int W = 8
) (
  // Configuration
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] pull,
  input  wire logic [W-1:0] no_pullup,
  input  wire logic [W-1:0] open_drain,
  input  wire logic [W-1:0] in_enable,
  input  wire logic [W-1:0] keep_in,
  input  wire logic         isolate,
  // Peripheral sharing
  input  wire logic [W-1:0] periph_oe,
  input  wire logic [W-1:0] periph_out,
  // Pad side
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe_n,
  output logic      [W-1:0] pad_pullup,
  output logic      [W-1:0] pin_rd
);
  logic [W-1:0] drive_val;
  logic [W-1:0] drive_en;

  always_comb begin
    drive_val = (periph_oe & periph_out) | (~periph_oe & latch); // R3 R7
    // Open drain never drives high
    drive_en  = (dir | periph_oe) & ~(open_drain & drive_val) & ~{W{isolate}}; // R1 R2 R5 R12 R21
    pad_out   = drive_val;
    pad_oe_n  = ~drive_en;
    // Pull-up off while low is driven
    pad_pullup = pull & ~no_pullup & ~(drive_en & ~drive_val) & ~{W{isolate}}; // R17 R22
    pin_rd = pin_in & in_enable & (isolate ? keep_in : {W{1'b1}}); // R10 R12 R13
  end
endmodule

/* tb/gpio_board.sv */
// Board model for one 8-pin port: resolves each pad from the block's drive,
// an external driver and the internal pull-up.
// Assumes the block's pad outputs are registered on clk.
`timescale 1ns/1ps
module gpio_board (
  // Block side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] pull_on,
  // Board side
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  output logic      [7:0] pin_in
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_drv[i]) pin_in[i] = ext_val[i];
      else if (pull_on[i]) pin_in[i] = 1'b1;
      // Floating pad never repeats the last drive
      else pin_in[i] = ~pin_out[i];
    end
  end
endmodule

/* tb/dual_gpio_port_chk.sv */
// Concurrent checks on the pad side of the two-port block.
// Assumes one clock domain and registered pad outputs.
`timescale 1ns/1ps
module dual_gpio_port_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Status
  input wire logic       stop_or_watch,
  input wire logic [7:0] ext_irq_enable,
  // Port 0 pads
  input wire logic [7:0] p0_pin_in,
  input wire logic [7:0] p0_pin_out,
  input wire logic [7:0] p0_pin_oe_n,
  input wire logic [7:0] p0_pullup,
  input wire logic [7:0] p0_analog_en,
  input wire logic [7:0] p0_din,
  input wire logic [7:0] p0_irq_level,
  input wire logic [1:0] cmp_pos_en,
  input wire logic [1:0] cmp_neg_en,
  // Port 1 pads and pulse outputs
  input wire logic [7:0] p1_pin_out,
  input wire logic [7:0] p1_pin_oe_n,
  input wire logic [7:0] p1_pullup,
  input wire logic [5:0] pulse_oe,
  input wire logic [5:0] pulse_out,
  input wire logic [5:0] p6_pulse_out,
  input wire logic [5:0] p6_pulse_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_float: assert property (!$past(nrst) |-> p0_pin_oe_n == 8'hff
    && p1_pin_oe_n == 8'hff && p0_analog_en == 8'hff) else $error("pads not idle after reset");
  a_irq_route: assert property ($past(nrst) && !$past(stop_or_watch) |->
    p0_irq_level == $past(p0_pin_in)) else $error("irq level not pin level");
  a_irq_keep: assert property ($past(nrst) |-> (p0_irq_level & $past(ext_irq_enable))
    == ($past(p0_pin_in) & $past(ext_irq_enable))) else $error("irq path blocked");
  a_din_gated: assert property ($past(nrst) |->
    (p0_din & ~$past(p0_pin_in)) == 8'h00) else $error("input high without pin");
  a_pull_low0: assert property ((p0_pullup & ~p0_pin_oe_n & ~p0_pin_out) == 8'h00)
    else $error("port 0 pull-up on low drive");
  a_pull_low1: assert property ((p1_pullup & ~p1_pin_oe_n & ~p1_pin_out) == 8'h00)
    else $error("port 1 pull-up on low drive");
  a_p12_nopull: assert property (p1_pullup[2] == 1'b0) else $error("pull-up on pin 2");
  a_pulse_remap: assert property ($past(nrst) |-> (p6_pulse_en & ~$past(pulse_oe)) == 6'h00
    && ((p6_pulse_out ^ $past(pulse_out)) & p6_pulse_en) == 6'h00) else $error("bad remap");
  a_cmp_analog: assert property ((cmp_pos_en & ~{p0_analog_en[3], p0_analog_en[0]}) == 2'h0
    && (cmp_neg_en & ~{p0_analog_en[4], p0_analog_en[1]}) == 2'h0) else $error("bad comparator");
endmodule
bind dual_gpio_port dual_gpio_port_chk i_dual_gpio_port_chk (
  .clk            (clk),
  .nrst           (nrst),
  .stop_or_watch  (stop_or_watch),
  .ext_irq_enable (ext_irq_enable),
  .p0_pin_in      (p0_pin_in),
  .p0_pin_out     (p0_pin_out),
  .p0_pin_oe_n    (p0_pin_oe_n),
  .p0_pullup      (p0_pullup),
  .p0_analog_en   (p0_analog_en),
  .p0_din         (p0_din),
  .p0_irq_level   (p0_irq_level),
  .cmp_pos_en     (cmp_pos_en),
  .cmp_neg_en     (cmp_neg_en),
  .p1_pin_out     (p1_pin_out),
  .p1_pin_oe_n    (p1_pin_oe_n),
  .p1_pullup      (p1_pullup),
  .pulse_oe       (pulse_oe),
  .pulse_out      (pulse_out),
  .p6_pulse_out   (p6_pulse_out),
  .p6_pulse_en    (p6_pulse_en)
);

/* tb/dual_gpio_port_pin_control_bench.sv */
// Self-checking bench: AHB-Lite register calls and pad comparisons.
// Assumes zero-wait slave; pads follow a register write within three edges.
`timescale 1ns/1ps
module dual_gpio_port_pin_control_bench
  import gpio_pkg::*;
;
  logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, rmw_read = 0, stop_or_watch = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0, cmp_pos_en, cmp_neg_en;
  logic [7:0]  ext_irq_enable = 0, p0_periph_oe = 0, p0_periph_out = 0, p0_pin_in, p1_pin_in;
  logic [7:0]  p0_pin_out, p0_pin_oe_n, p0_pullup, p0_analog_en, p0_din, p0_irq_level;
  logic [7:0]  p1_pin_out, p1_pin_oe_n, p1_pullup, p1_din;
  logic [5:0]  pulse_oe = 0, pulse_out = 0, p6_pulse_out, p6_pulse_en;
  logic        hreadyout, hresp;
  int          num_errors = 0, checks_done = 0;
  logic [7:0]  p1_ext_val = 8'h00, p1_ext_drv = 8'hff;
  localparam logic [7:0] RST_OFFS [8] = '{OFF_P0_DATA, OFF_P0_DIR, OFF_P0_PUL, OFF_P0_ADIS,
    OFF_P1_DATA, OFF_P1_DIR, OFF_P1_PUL, OFF_CTRL};
  always #25 clk = ~clk;
  // Open drain on pin 7 so the float-on-one path is exercised
  dual_gpio_port #(.P1_OPEN_DRAIN(8'h80)) i_dual_gpio_port (.clk(clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout),
    .rmw_read(rmw_read), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .stop_or_watch(stop_or_watch), .ext_irq_enable(ext_irq_enable), .p0_pin_in(p0_pin_in),
    .p0_periph_oe(p0_periph_oe), .p0_periph_out(p0_periph_out), .p0_pin_out(p0_pin_out),
    .p0_pin_oe_n(p0_pin_oe_n), .p0_pullup(p0_pullup), .p0_analog_en(p0_analog_en),
    .p0_din(p0_din), .p0_irq_level(p0_irq_level), .cmp_pos_en(cmp_pos_en),
    .cmp_neg_en(cmp_neg_en), .p1_pin_in(p1_pin_in), .pulse_oe(pulse_oe), .pulse_out(pulse_out),
    .p1_pin_out(p1_pin_out), .p1_pin_oe_n(p1_pin_oe_n), .p1_pullup(p1_pullup), .p1_din(p1_din),
    .p6_pulse_out(p6_pulse_out), .p6_pulse_en(p6_pulse_en));
  gpio_board i_gpio_board0 (.pin_out(p0_pin_out), .oe_n(p0_pin_oe_n), .pull_on(p0_pullup),
    .ext_val(8'h3d), .ext_drv(8'hff), .pin_in(p0_pin_in));
  gpio_board i_gpio_board1 (.pin_out(p1_pin_out), .oe_n(p1_pin_oe_n), .pull_on(p1_pullup),
    .ext_val(p1_ext_val), .ext_drv(p1_ext_drv), .pin_in(p1_pin_in));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic [7:0] a, input logic wr, input logic rmw, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= HTRANS_NONSEQ; hwrite <= wr; rmw_read <= rmw;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; rmw_read <= 1'b0; hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, 1'b0, d);
  endtask
  task rd(input logic [7:0] a, input logic rmw, input logic [7:0] exp);
    xfer(a, 1'b0, rmw, 8'h00);
    chk(hrdata, {24'h0, exp});
  endtask
  // Lets a register write reach the pads
  task settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (RST_OFFS[i]) rd(RST_OFFS[i], 1'b0, 8'h00);
    rd(OFF_CMP, 1'b0, 8'h05);
    rd(8'h40, 1'b0, 8'h00);
    $display("test reset done");
    wr(OFF_P0_DIR, 8'hff); wr(OFF_P0_DATA, 8'ha5); settle();
    chk(p0_pin_out, 8'ha5); chk(p0_pin_oe_n, 8'h00);
    rd(OFF_P0_DATA, 1'b0, 8'ha5);
    wr(OFF_P0_DIR, 8'h00); wr(OFF_P0_ADIS, 8'hff); wr(OFF_P0_DATA, 8'h0f); settle();
    chk(p0_pin_oe_n, 8'hff); chk(p0_analog_en, 8'h00);
    rd(OFF_P0_DATA, 1'b0, 8'h3d); rd(OFF_P0_DATA, 1'b1, 8'h0f);
    wr(OFF_P0_ADIS, 8'h00); settle();
    rd(OFF_P0_DATA, 1'b0, 8'h00); wr(OFF_P0_ADIS, 8'hff);
    p0_periph_oe <= 8'hff; p0_periph_out <= 8'h99; settle();
    chk(p0_pin_out, 8'h99); chk(p0_pin_oe_n, 8'h00);
    rd(OFF_P0_DATA, 1'b0, 8'h99); rd(OFF_P0_DATA, 1'b1, 8'h0f);
    p0_periph_oe <= 8'h00;
    $display("test direction done");
    wr(OFF_P0_PUL, 8'hff); wr(OFF_P0_DIR, 8'hff); wr(OFF_P0_DATA, 8'h00); settle();
    chk(p0_pullup, 8'h00); wr(OFF_P0_DATA, 8'hff); settle(); chk(p0_pullup, 8'hff);
    wr(OFF_P1_PUL, 8'hff); settle(); chk(p1_pullup, 8'hfb); rd(OFF_P1_PUL, 1'b0, 8'hff);
    wr(OFF_P1_DIR, 8'hff); wr(OFF_P1_DATA, 8'h80); p1_ext_val <= 8'hff; settle();
    chk(p1_pin_oe_n, 8'h80); chk(p1_pin_out, 8'h80);
    rd(OFF_P1_DATA, 1'b0, 8'h80);
    ext_irq_enable <= 8'h01; wr(OFF_CTRL, 8'h01); stop_or_watch <= 1'b1; settle();
    chk(p0_pin_oe_n, 8'hff); chk(p1_pin_oe_n, 8'hff); chk(p1_din, 8'h00);
    chk(p0_din, 8'h01);
    wr(OFF_CTRL, 8'h00); settle();
    chk(p0_pin_oe_n, 8'h00); chk(p0_pin_out, 8'hff); chk(p1_pin_oe_n, 8'h80);
    @(posedge clk);
    stop_or_watch <= 1'b0;
    $display("test standby done");
    wr(OFF_P1_DIR, 8'h00); wr(OFF_P1_DATA, 8'h00);
    pulse_oe <= 6'h3f; pulse_out <= 6'h2a; settle();
    chk(p1_pin_out, 8'h52); chk(p1_pin_oe_n, 8'h84); chk(p6_pulse_en, 6'h00);
    wr(OFF_CTRL, 8'h02); settle();
    chk(p6_pulse_en, 6'h3f); chk(p6_pulse_out, 6'h2a); chk(p1_pin_oe_n, 8'hff);
    wr(OFF_P0_PUL, 8'h00); wr(OFF_P0_DIR, 8'h00); wr(OFF_P0_ADIS, 8'h00);
    wr(OFF_CMP, 8'h00); settle(); chk(cmp_pos_en, 2'h3); chk(cmp_neg_en, 2'h3);
    wr(OFF_CMP, 8'h02); settle(); chk(cmp_pos_en, 2'h3); chk(cmp_neg_en, 2'h2);
    wr(OFF_CMP, 8'h04); settle(); chk(cmp_pos_en, 2'h1); chk(cmp_neg_en, 2'h1);
    $display("test peripherals done");
    wr(OFF_P0_DIR, 8'h3c); wr(OFF_P0_ADIS, 8'hc3); wr(OFF_P1_DIR, 8'h0f); settle();
    chk(p0_analog_en, 8'h3c);
    // Reset in mid-run must clear what was just set
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(OFF_P0_DIR, 1'b0, 8'h00); rd(OFF_P0_ADIS, 1'b0, 8'h00);
    rd(OFF_P1_DIR, 1'b0, 8'h00); chk(p0_analog_en, 8'hff);
    $display("test second reset done");
    close_out();
  end
endmodule
